// ---- src/rhpd_pkg.sv ----
// Purpose: constants of the root hub port power descriptor block
// Assumes: 32-bit register port, byte offsets as printed
// Notes: shared by the register bank and the power switch
package rhpd_pkg;
    // =====================================================
    // register offsets
    localparam logic [7:0] RHPD_OFS_DESC_FIRST = 8'h48;
    localparam logic [7:0] RHPD_OFS_DESC_SECOND = 8'h4c;
    localparam logic [7:0] RHPD_OFS_HUB_STATUS = 8'h50;
    // =====================================================
    // first descriptor fields
    localparam int RHPD_POS_NDP_LSB = 0;
    localparam int RHPD_POS_PSM = 8;
    localparam int RHPD_POS_NPS = 9;
    localparam int RHPD_POS_DT = 10;
    localparam int RHPD_POS_OVERCURRENT_REPORT_MODE = 11;
    localparam int RHPD_POS_NOCP = 12;
    localparam int RHPD_POS_POTPGT_LSB = 24;
    // =====================================================
    // second descriptor and hub status fields
    localparam int RHPD_POS_DR_LSB = 0;
    localparam int RHPD_POS_MASK_LSB = 16;
    localparam int RHPD_POS_CLR_GLOBAL = 0;
    localparam int RHPD_POS_SET_GLOBAL = 16;
    // =====================================================
    // reset values
    localparam logic [7:0] RHPD_RST_POTPGT = 8'hff;
    localparam logic RHPD_RST_NPS = 1'b0;
    localparam logic RHPD_RST_PSM = 1'b1;
    localparam logic RHPD_RST_NOCP = 1'b0;
    localparam logic RHPD_RST_OVERCURRENT_REPORT_MODE = RHPD_RST_PSM;
    localparam logic [15:0] RHPD_RST_MASK_BASE = 16'h0002;
    localparam logic [15:0] RHPD_RST_MASK_PORT2 = 16'h0004;
    localparam logic [15:0] RHPD_RST_DR = 16'h0000;
    localparam logic [15:0] RHPD_RSVD_BIT0 = 16'h0001;
    // =====================================================
    // port count limits
    localparam int RHPD_MIN_PORTS = 1;
    localparam int RHPD_MAX_PORTS = 15;
endpackage : rhpd_pkg

// ---- src/rhpd_pwr_if.sv ----
// Purpose: carries power settings and commands to the port power switch
// Assumes: all signals on i_clk_sys
// Notes: port p sits at vector index p, index 0 unused
`timescale 1ns/1ps
interface rhpd_pwr_if #(parameter int N_PORTS = 2);
    logic no_power_switching;
    logic power_switching_mode;
    logic [N_PORTS:0] port_power_control_mask;
    logic global_set;
    logic global_clr;
    logic [N_PORTS:0] port_set;
    logic [N_PORTS:0] port_clr;
    logic [N_PORTS:0] port_power;
    modport bank (output no_power_switching, output power_switching_mode,
        output port_power_control_mask, output global_set, output global_clr,
        output port_set, output port_clr, input port_power);
    modport sw (input no_power_switching, input power_switching_mode,
        input port_power_control_mask, input global_set, input global_clr,
        input port_set, input port_clr, output port_power);
endinterface : rhpd_pwr_if

// ---- src/rhpd_port_power.sv ----
// Purpose: per-port power state driven by global and per-port commands
// Assumes: commands are one-cycle pulses on i_clk_sys
// Notes: a set wins over a clear of the same kind, global or per-port, in the same cycle
`timescale 1ns/1ps
module rhpd_port_power #(
    parameter int N_PORTS = 2
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // settings and commands
    rhpd_pwr_if.sw pwr
);
    import rhpd_pkg::*;

    typedef struct packed {
        logic [N_PORTS:0] power;
    } rhpd_pp_state_t;

    rhpd_pp_state_t state_reg;
    rhpd_pp_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.power[0] = 1'b0;
        for (int p = 1; p <= N_PORTS; p++) begin
            if (pwr.no_power_switching) begin
                state_next.power[p] = 1'b1;
            end else if (!pwr.power_switching_mode || !pwr.port_power_control_mask[p]) begin
                // ganged: only global commands, mask ignored in global mode
                if (pwr.global_set) begin
                    state_next.power[p] = 1'b1;
                end else if (pwr.global_clr) begin
                    state_next.power[p] = 1'b0;
                end
            end else begin
                if (pwr.port_set[p]) begin
                    state_next.power[p] = 1'b1;
                end else if (pwr.port_clr[p]) begin
                    state_next.power[p] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= '0;
        end else if (i_clk_en) begin
            state_reg <= state_next;
        end
    end

    assign pwr.port_power = state_reg.power;
endmodule : rhpd_port_power

// ---- src/rhpd_desc_regs.sv ----
// Purpose: root hub descriptor registers and port power control
// Assumes: single-cycle register strobes from the host bus on i_clk_sys
// Notes: read data is registered, one cycle after the read strobe
`timescale 1ns/1ps
module rhpd_desc_regs #(
    parameter logic [7:0] N_PORTS = 8'd2
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    // per-port power commands from the port status logic
    input wire logic [int'(N_PORTS):1] i_port_set_power,
    input wire logic [int'(N_PORTS):1] i_port_clr_power,
    // port power and settings
    output logic [int'(N_PORTS):1] o_port_power,
    output logic o_overcurrent_report_mode,
    output logic o_no_overcurrent_protect,
    output logic [15:0] o_device_removable
);
    import rhpd_pkg::*;

    // =====================================================
    // port count and reset image
    // the reported count stays inside the legal range even for a stray parameter value
    function automatic int legal_count(input int n);
        int res;
        res = n;
        if (n < RHPD_MIN_PORTS) begin
            res = RHPD_MIN_PORTS;
        end else if (n > RHPD_MAX_PORTS) begin
            res = RHPD_MAX_PORTS;
        end
        return res;
    endfunction : legal_count

    localparam int NP = int'(N_PORTS);
    localparam logic [7:0] NDP_VALUE = 8'(legal_count(NP));
    // bit 18 of the second register set for two or more ports
    localparam logic [15:0] MASK_RST = (NP >= 2) ?
        (RHPD_RST_MASK_BASE | RHPD_RST_MASK_PORT2) : RHPD_RST_MASK_BASE;

    // =====================================================
    // register state
    typedef struct packed {
        // first descriptor settings
        logic [7:0] potpgt;
        logic no_overcurrent_protect;
        logic overcurrent_report_mode;
        logic no_power_switching;
        logic power_switching_mode;
        // second descriptor fields
        logic [15:0] port_power_control_mask;
        logic [15:0] device_removable;
        // read data lives in the state so a frozen block keeps its last answer
        logic [31:0] rdata;
    } rhpd_state_t;

    localparam rhpd_state_t RST_STATE = '{
        potpgt: RHPD_RST_POTPGT,
        no_overcurrent_protect: RHPD_RST_NOCP,
        overcurrent_report_mode: RHPD_RST_OVERCURRENT_REPORT_MODE,
        no_power_switching: RHPD_RST_NPS,
        power_switching_mode: RHPD_RST_PSM,
        port_power_control_mask: MASK_RST,
        device_removable: RHPD_RST_DR,
        rdata: 32'h0000_0000
    };

    rhpd_state_t state_reg;
    rhpd_state_t state_next;
    logic [31:0] first_word;
    logic [31:0] second_word;
    logic [31:0] status_word;
    logic [31:0] read_word;
    logic wr_first;
    logic wr_second;
    logic wr_status;
    wire logic [NP:0] mask_vec;
    wire logic [NP:0] set_vec;
    wire logic [NP:0] clr_vec;

    rhpd_pwr_if #(.N_PORTS(NP)) pwr ();

    // =====================================================
    // access decode
    // one address compare per register, shared by writes and commands
    assign wr_first = i_reg_wr && (i_reg_addr == RHPD_OFS_DESC_FIRST);
    assign wr_second = i_reg_wr && (i_reg_addr == RHPD_OFS_DESC_SECOND);
    assign wr_status = i_reg_wr && (i_reg_addr == RHPD_OFS_HUB_STATUS);

    // =====================================================
    // reserved bit 0 of a port field
    // bit 0 always takes its reset value, so no write can reach it
    function automatic logic [15:0] keep_rsvd(input logic [15:0] wval,
        input logic [15:0] rval);
        logic [15:0] res;
        res = (wval & ~RHPD_RSVD_BIT0) | (rval & RHPD_RSVD_BIT0);
        return res;
    endfunction : keep_rsvd

    // =====================================================
    // read views
    always_comb begin
        first_word = 32'h0000_0000;
        first_word[RHPD_POS_POTPGT_LSB +: 8] = state_reg.potpgt;
        first_word[RHPD_POS_NOCP] = state_reg.no_overcurrent_protect;
        first_word[RHPD_POS_OVERCURRENT_REPORT_MODE] = state_reg.overcurrent_report_mode;
        // device type fixed at 0, the root hub is never a compound device
        first_word[RHPD_POS_DT] = 1'b0;
        first_word[RHPD_POS_NPS] = state_reg.no_power_switching;
        first_word[RHPD_POS_PSM] = state_reg.power_switching_mode;
        first_word[RHPD_POS_NDP_LSB +: 8] = NDP_VALUE;
        second_word = {state_reg.port_power_control_mask, state_reg.device_removable};
        // hub status only takes commands, set-global-power reads back 0
        status_word = 32'h0000_0000;
    end

    // =====================================================
    // read select
    always_comb begin
        case (i_reg_addr)
            RHPD_OFS_DESC_FIRST: read_word = first_word;
            RHPD_OFS_DESC_SECOND: read_word = second_word;
            RHPD_OFS_HUB_STATUS: read_word = status_word;
            default: read_word = 32'h0000_0000;
        endcase
    end

    // =====================================================
    // register writes and read capture
    always_comb begin
        state_next = state_reg;
        if (wr_first) begin
            state_next.potpgt = i_reg_wdata[RHPD_POS_POTPGT_LSB +: 8];
            state_next.no_overcurrent_protect = i_reg_wdata[RHPD_POS_NOCP];
            state_next.overcurrent_report_mode = i_reg_wdata[RHPD_POS_OVERCURRENT_REPORT_MODE];
            state_next.no_power_switching = i_reg_wdata[RHPD_POS_NPS];
            state_next.power_switching_mode = i_reg_wdata[RHPD_POS_PSM];
        end
        if (wr_second) begin
            // reserved bit 0 keeps its reset value
            state_next.port_power_control_mask =
                keep_rsvd(i_reg_wdata[RHPD_POS_MASK_LSB +: 16], MASK_RST);
            state_next.device_removable =
                keep_rsvd(i_reg_wdata[RHPD_POS_DR_LSB +: 16], RHPD_RST_DR);
        end
        // a read in the same cycle as a write returns the old contents
        if (i_reg_rd) begin
            state_next.rdata = read_word;
        end
    end

    // =====================================================
    // state register, frozen while the clock enable is low
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= RST_STATE;
        end else if (i_clk_en) begin
            state_reg <= state_next;
        end
    end

    // =====================================================
    // power commands to the switch
    assign pwr.no_power_switching = state_reg.no_power_switching;
    assign pwr.power_switching_mode = state_reg.power_switching_mode;
    // commands are single-cycle, the switch only takes them at an enabled edge
    assign pwr.global_set = wr_status && i_reg_wdata[RHPD_POS_SET_GLOBAL];
    assign pwr.global_clr = wr_status && i_reg_wdata[RHPD_POS_CLR_GLOBAL];

    // =====================================================
    // per-port fan-out, port p at index p, index 0 unused
    assign mask_vec[0] = 1'b0;
    assign set_vec[0] = 1'b0;
    assign clr_vec[0] = 1'b0;
    for (genvar p = 1; p <= NP; p++) begin : g_port
        assign mask_vec[p] = state_reg.port_power_control_mask[p];
        assign set_vec[p] = i_port_set_power[p];
        assign clr_vec[p] = i_port_clr_power[p];
    end
    assign pwr.port_power_control_mask = mask_vec;
    assign pwr.port_set = set_vec;
    assign pwr.port_clr = clr_vec;

    rhpd_port_power #(.N_PORTS(NP)) u_port_power (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .pwr(pwr.sw)
    );

    // =====================================================
    // outputs
    // every output comes straight from a flip-flop
    assign o_reg_rdata = state_reg.rdata;
    assign o_port_power = pwr.port_power[NP:1];
    assign o_overcurrent_report_mode = state_reg.overcurrent_report_mode;
    assign o_no_overcurrent_protect = state_reg.no_overcurrent_protect;
    assign o_device_removable = state_reg.device_removable;
endmodule : rhpd_desc_regs

// ---- verif/rhpd_desc_regs_monitor.sv ----
// Purpose: checker of the descriptor register bank ports
// Assumes: clock enable high while power commands are issued
// Notes: shadows mode bits and mask from register writes
`timescale 1ns/1ps
module rhpd_desc_regs_monitor #(
    parameter logic [7:0] N_PORTS = 8'd2
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [31:0] i_reg_wdata,
    input wire logic [31:0] o_reg_rdata,
    // power and settings
    input wire logic [int'(N_PORTS):1] i_port_set_power,
    input wire logic [int'(N_PORTS):1] i_port_clr_power,
    input wire logic [int'(N_PORTS):1] o_port_power,
    input wire logic o_overcurrent_report_mode,
    input wire logic o_no_overcurrent_protect,
    input wire logic [15:0] o_device_removable
);
    import rhpd_pkg::*;
    localparam int N = int'(N_PORTS);
    logic nps_reg, psm_reg, w48, w4c, r48, r4c, g50;
    logic [15:0] mask_reg;
    logic [N:1] msk;
    assign w48 = i_clk_en && i_reg_wr && i_reg_addr == RHPD_OFS_DESC_FIRST;
    assign w4c = i_clk_en && i_reg_wr && i_reg_addr == RHPD_OFS_DESC_SECOND;
    assign r48 = i_clk_en && i_reg_rd && i_reg_addr == RHPD_OFS_DESC_FIRST;
    assign r4c = i_clk_en && i_reg_rd && i_reg_addr == RHPD_OFS_DESC_SECOND;
    assign g50 = i_clk_en && i_reg_wr && i_reg_addr == RHPD_OFS_HUB_STATUS && !nps_reg;
    assign msk = mask_reg[N:1];
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            nps_reg <= RHPD_RST_NPS;
            psm_reg <= RHPD_RST_PSM;
            mask_reg <= (N > 1) ? 16'h0006 : 16'h0002;
        end else begin
            if (w48) begin
                nps_reg <= i_reg_wdata[RHPD_POS_NPS];
                psm_reg <= i_reg_wdata[RHPD_POS_PSM];
            end
            if (w4c) begin
                mask_reg <= i_reg_wdata[31:16];
            end
        end
    end
    // =====================================================
    // properties
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    property p_ndp; r48 |=> o_reg_rdata[7:0] == N_PORTS; endproperty
    a_ndp: assert property (p_ndp) else $error("port count wrong");
    property p_rsvd; r4c |=> !o_reg_rdata[16] && !o_reg_rdata[0]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_dr; w4c |=> o_device_removable == ($past(i_reg_wdata[15:0]) & 16'hfffe); endproperty
    a_dr: assert property (p_dr) else $error("removable wrong");
    property p_nps; nps_reg && i_clk_en |=> &o_port_power; endproperty
    a_nps: assert property (p_nps) else $error("port unpowered");
    property p_gset; g50 && i_reg_wdata[16] && !psm_reg |=> &o_port_power; endproperty
    a_gset: assert property (p_gset) else $error("global set");
    property p_gpp;
        g50 && i_reg_wdata[16] && psm_reg && i_port_set_power == 0 && i_port_clr_power == 0
        |=> &(o_port_power | msk) && (o_port_power & msk) == ($past(o_port_power) & msk);
    endproperty
    a_gpp: assert property (p_gpp) else $error("per-port set");
    property p_gclr; g50 && i_reg_wdata[0] && !i_reg_wdata[16] && !psm_reg |=> o_port_power == 0;
    endproperty
    a_gclr: assert property (p_gclr) else $error("global clear");
    property p_ign;
        !nps_reg && !$past(nps_reg) && !psm_reg && i_clk_en && !i_reg_wr |=> $stable(o_port_power);
    endproperty
    a_ign: assert property (p_ign) else $error("power moved");
    c_gset: cover property (g50 && i_reg_wdata[16]);
    c_nps: cover property (nps_reg ##1 &o_port_power);
    c_rd: cover property (r4c);
endmodule : rhpd_desc_regs_monitor
bind rhpd_desc_regs rhpd_desc_regs_monitor #(.N_PORTS(N_PORTS)) u_mon (.i_clk_sys, .i_sys_rst,
    .i_clk_en, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_port_set_power,
    .i_port_clr_power, .o_port_power, .o_overcurrent_report_mode, .o_no_overcurrent_protect,
    .o_device_removable);

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench of the descriptor register bank
// Assumes: two ports, inputs driven on the falling edge
// Notes: read data checked one cycle after the read strobe
`timescale 1ns/1ps
module tb_top;
    import rhpd_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_clk_en = 1'b1;
    logic [7:0] i_reg_addr = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [31:0] i_reg_wdata = 32'h0;
    logic [2:1] i_port_set_power = 2'h0;
    logic [2:1] i_port_clr_power = 2'h0;
    logic [31:0] o_reg_rdata;
    logic [2:1] o_port_power;
    logic o_overcurrent_report_mode, o_no_overcurrent_protect;
    logic [15:0] o_device_removable;
    int fails = 0;
    int checked = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    rhpd_desc_regs #(.N_PORTS(8'd2)) DUT (.i_clk_sys, .i_sys_rst, .i_clk_en, .i_reg_addr,
        .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_port_set_power, .i_port_clr_power,
        .o_port_power, .o_overcurrent_report_mode, .o_no_overcurrent_protect, .o_device_removable);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge i_clk_sys);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge i_clk_sys);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk_sys);
        i_reg_rd = 1'b0;
        chk("rdata", o_reg_rdata, e);
    endtask : rd
    task automatic pw(input logic [2:1] e);
        chk("power", {30'h0, o_port_power}, {30'h0, e});
    endtask : pw
    task automatic pp(input logic [2:1] s, input logic [2:1] c, input logic [2:1] e);
        @(negedge i_clk_sys);
        i_port_set_power = s;
        i_port_clr_power = c;
        @(negedge i_clk_sys);
        i_port_set_power = 2'h0;
        i_port_clr_power = 2'h0;
        pw(e);
    endtask : pp
    task automatic print_verdict();
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #20000;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (3) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        rd(RHPD_OFS_DESC_FIRST, 32'hff000902);
        rd(RHPD_OFS_DESC_SECOND, 32'h00060000);
        chk("overcurrent_report_mode", {31'h0, o_overcurrent_report_mode}, 32'h1);
        chk("nocp", {31'h0, o_no_overcurrent_protect}, 32'h0);
        rd(8'h54, 32'h0);
        wr(RHPD_OFS_DESC_SECOND, 32'hffffffff);
        rd(RHPD_OFS_DESC_SECOND, 32'hfffefffe);
        wr(RHPD_OFS_DESC_SECOND, 32'h00040006);
        chk("removable", {16'h0, o_device_removable}, 32'h6);
        wr(RHPD_OFS_HUB_STATUS, 32'h00010000);
        pw(2'b01);
        pp(2'b00, 2'b11, 2'b01);
        pp(2'b10, 2'b00, 2'b11);
        wr(RHPD_OFS_HUB_STATUS, 32'h1);
        pw(2'b10);
        wr(RHPD_OFS_DESC_FIRST, 32'hff00180f);
        rd(RHPD_OFS_DESC_FIRST, 32'hff001802);
        chk("nocp", {31'h0, o_no_overcurrent_protect}, 32'h1);
        pp(2'b01, 2'b10, 2'b10);
        wr(RHPD_OFS_HUB_STATUS, 32'h00010000);
        pw(2'b11);
        wr(RHPD_OFS_HUB_STATUS, 32'h1);
        pw(2'b00);
        wr(RHPD_OFS_DESC_FIRST, 32'hff000b00);
        @(negedge i_clk_sys);
        pw(2'b11);
        wr(RHPD_OFS_HUB_STATUS, 32'h1);
        pp(2'b00, 2'b11, 2'b11);
        i_clk_en = 1'b0;
        wr(RHPD_OFS_DESC_SECOND, 32'h0);
        i_clk_en = 1'b1;
        rd(RHPD_OFS_DESC_SECOND, 32'h00040006);
        i_sys_rst = 1'b1;
        @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        rd(RHPD_OFS_DESC_SECOND, 32'h00060000);
        pw(2'b00);
        print_verdict();
    end
endmodule : tb_top
